// *** rtl/mft_timer.sv ***
// Multi-function timer chain with overflow, periodic, watchdog and reset timing
`timescale 1ns/10ps
module mft_timer (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [mft_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [mft_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [mft_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       stop_i,
  input  wire logic                       reset_pin_n_i,
  output logic                            reset_pin_n_o,
  output logic                            reset_pin_oe_o,
  output logic                            cpu_reset_o,
  output logic                            irq_o
);
  import mft_pkg::*;

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [5:0] idx);
    reg_hit = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction : reg_hit

  // True when every chain bit up to msb is one, i.e. that stage carries on the next edge
  function automatic logic carry_out(input logic [CHAIN_W-1:0] v, input logic [4:0] msb);
    logic [CHAIN_W-1:0] m;
    m = {CHAIN_W{1'b1}} >> (5'd16 - msb);
    carry_out = &(v | ~m);
  endfunction : carry_out

  mft_state_e         state_reg;
  mft_state_e         state_next;
  logic [CHAIN_W-1:0] chain_reg;
  logic [CHAIN_W-1:0] chain_next;
  logic               ovf_flag_reg;
  logic               per_flag_reg;
  logic               ovf_en_reg;
  logic               per_en_reg;
  logic [1:0]         rate_reg;
  logic               wd_en_reg;
  logic               rec_long_reg;
  logic [2:0]         wd_cnt_reg;
  logic [2:0]         wd_cnt_next;
  logic               ack_reg;
  logic [DAT_W-1:0]   dat_reg;
  logic               irq_reg;
  logic               cpu_rst_reg;
  logic               pin_oe_reg;
  logic               pin_low_reg;
  logic               pin_sync_n;
  logic [1:0]         oe_hist_reg;

  mft_sync #(
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (reset_pin_n_i),
    .sync_o  (pin_sync_n)
  );

  wire              bus_req   = wb_cyc_i & wb_stb_i;
  wire              ack_next  = bus_req & ~ack_reg;
  // A write takes effect at the edge where the master sees ack
  wire              wr_fire   = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  wire              hit_cs    = reg_hit(wb_adr_i, IDX_CTRL_STATUS);
  wire              hit_cnt   = reg_hit(wb_adr_i, IDX_COUNT);
  wire              hit_cfg   = reg_hit(wb_adr_i, IDX_SYS_CONFIG);
  wire              hit_svc   = reg_hit(wb_adr_i, IDX_WD_SERVICE);
  wire              wr_cs     = wr_fire & hit_cs;
  wire              wr_cfg    = wr_fire & hit_cfg;
  wire              in_run    = (state_reg == MFT_RUN);
  // Our own pin drive must not read back as an external reset; the history
  // covers the two-flop lag after the drive ends
  wire              ext_rst   = ~pin_sync_n & ~pin_oe_reg & ~(|oe_hist_reg);
  wire [4:0]        per_msb   = PER_TAP_BASE_MSB + {3'h0, rate_reg};
  wire              ovf_evt   = in_run & carry_out(chain_reg, OVF_TAP_MSB);
  wire              per_evt   = in_run & carry_out(chain_reg, per_msb);
  wire              stop_entry = in_run & stop_i;
  wire              por_done  = (state_reg == MFT_POR) & (chain_reg == POR_LAST);
  wire [CHAIN_W-1:0] rec_last = rec_long_reg ? LONG_LAST : SHORT_LAST;
  wire              rec_done  = (state_reg == MFT_RECOVER) & (chain_reg == rec_last);
  wire              wdrst_done = (state_reg == MFT_WDRST) & (chain_reg == PULSE_LAST);
  // watchdog counts selected tap events while enabled
  wire              wd_tick   = per_evt & wd_en_reg;
  wire              wd_expire = wd_tick & (wd_cnt_reg == WD_LAST);
  wire              wd_service = wr_fire & hit_svc & ~wb_dat_i[BIT_SVC_DATA];
  wire              regs_clear = ext_rst | (state_reg == MFT_POR) | (state_reg == MFT_WDRST);
  wire              chain_clr = ext_rst | por_done | rec_done | stop_entry | wd_expire |
                                wdrst_done | (state_reg == MFT_STOP);
  wire              ovf_clr   = wr_cs & wb_dat_i[BIT_OVF_CLEAR];
  wire              per_clr   = wr_cs & wb_dat_i[BIT_PER_CLEAR];
  wire              irq_next  = (ovf_flag_reg & ovf_en_reg) | (per_flag_reg & per_en_reg);
  wire [7:0]        cs_read   = {ovf_flag_reg, per_flag_reg, ovf_en_reg, per_en_reg,
                                 2'h0, rate_reg};
  wire [7:0]        cfg_read  = {6'h00, rec_long_reg, wd_en_reg};
  wire [7:0]        rd_byte   = hit_cs  ? cs_read :
                                hit_cnt ? chain_reg[CNT_MSB:CNT_LSB] :
                                hit_cfg ? cfg_read : 8'h00;

  // sequencing of power-on, stop and watchdog reset
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MFT_POR:
        if (por_done)
          state_next = MFT_RUN;
      MFT_RUN:
        if (wd_expire)
          state_next = MFT_WDRST;
        else if (stop_entry)
          state_next = MFT_STOP;
      MFT_STOP:
        if (!stop_i || ext_rst)
          state_next = MFT_RECOVER;
      MFT_RECOVER:
        if (rec_done)
          state_next = MFT_RUN;
      MFT_WDRST:
        if (wdrst_done)
          state_next = MFT_RUN;
      default:
        state_next = MFT_POR;
    endcase
  end

  // one chain, prescaler in the two low bits
  assign chain_next = chain_clr ? '0 : chain_reg + 17'h00001;

  // only the divide-by-eight stage is touched by a service
  always_comb
  begin
    wd_cnt_next = wd_cnt_reg;
    if (chain_clr || !wd_en_reg || wd_service)
      wd_cnt_next = 3'h0;
    else if (wd_tick)
      wd_cnt_next = wd_cnt_reg + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg  <= MFT_POR;
      chain_reg  <= '0;
      wd_cnt_reg <= 3'h0;
    end
    else
    begin
      state_reg  <= state_next;
      chain_reg  <= chain_next;
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  // Flags: a set in the same cycle as a clear-bit write wins; stop entry and resets clear first
  always_ff @(posedge clk_i)
  begin
    if (rst_i || regs_clear || stop_entry)
    begin
      ovf_flag_reg <= 1'b0;
      per_flag_reg <= 1'b0;
    end
    else
    begin
      ovf_flag_reg <= ovf_evt | (ovf_flag_reg & ~ovf_clr);
      per_flag_reg <= per_evt | (per_flag_reg & ~per_clr);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || regs_clear || stop_entry)
    begin
      ovf_en_reg <= 1'b0;
      per_en_reg <= 1'b0;
    end
    else if (wr_cs)
    begin
      ovf_en_reg <= wb_dat_i[BIT_OVF_IRQ_EN];
      per_en_reg <= wb_dat_i[BIT_PER_IRQ_EN];
    end
  end

  // rate select returns to slowest on every reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || regs_clear)
      rate_reg <= RST_RATE;
    else if (wr_cs)
      rate_reg <= wb_dat_i[BIT_RATE_MSB:BIT_RATE_LSB];
  end

  // watchdog enabled out of reset, software may disable
  always_ff @(posedge clk_i)
  begin
    if (rst_i || regs_clear)
    begin
      wd_en_reg    <= RST_WD_ENABLE;
      rec_long_reg <= RST_REC_LONG;
    end
    else if (wr_cfg)
    begin
      wd_en_reg    <= wb_dat_i[BIT_WD_ENABLE];
      rec_long_reg <= wb_dat_i[BIT_REC_LONG];
    end
  end

  // reads answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= ack_next ? {24'h000000, rd_byte} : '0;
    end
  end

  // interrupt level, registered from the enabled flags
  // core reset and open-drain pin drive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg     <= 1'b0;
      cpu_rst_reg <= 1'b1;
      pin_oe_reg  <= 1'b0;
      pin_low_reg <= 1'b0;
      oe_hist_reg <= 2'h0;
    end
    else
    begin
      oe_hist_reg <= {oe_hist_reg[0], pin_oe_reg};
      irq_reg     <= irq_next;
      cpu_rst_reg <= (state_next == MFT_POR) | (state_next == MFT_WDRST) | ext_rst;
      pin_oe_reg  <= (state_next == MFT_WDRST);
      pin_low_reg <= 1'b0;
    end
  end

  assign wb_ack_o       = ack_reg;
  assign wb_dat_o       = dat_reg;
  assign irq_o          = irq_reg;
  assign cpu_reset_o    = cpu_rst_reg;
  assign reset_pin_oe_o = pin_oe_reg;
  assign reset_pin_n_o  = pin_low_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_por_end;
    state_reg == MFT_POR && chain_reg == POR_LAST;
  endsequence

  sequence s_fresh_count;
    state_reg == MFT_RUN && chain_reg == 17'h00000 ##1 chain_reg == 17'h00001;
  endsequence

  chk_prescale_step: assert property (
    (in_run && !chain_clr && chain_reg[1:0] == 2'h3) |=>
      chain_reg[CNT_MSB:CNT_LSB] == $past(chain_reg[CNT_MSB:CNT_LSB]) + 8'h01)
    else $error("counter did not advance after four bus cycles");

  chk_ovf_set: assert property (
    (ovf_evt && !regs_clear && !stop_entry) |=>
      ovf_flag_reg && chain_reg[CNT_MSB:CNT_LSB] == 8'h00)
    else $error("overflow flag not set on counter wrap");

  chk_per_set: assert property (
    (per_evt && !regs_clear && !stop_entry) |=> per_flag_reg)
    else $error("periodic flag not set on selected tap");

  chk_per_irq: assert property (
    (per_flag_reg && per_en_reg) |=> irq_o)
    else $error("enabled periodic flag gave no interrupt");

  chk_stop_recover: assert property (
    rec_done |=> state_reg == MFT_RUN && chain_reg == 17'h00000)
    else $error("stop recovery did not clear and resume");

  chk_ovf_irq: assert property (
    (ovf_flag_reg && ovf_en_reg) |=> irq_o)
    else $error("enabled overflow flag gave no interrupt");

  chk_ovf_clear: assert property (
    (ovf_clr && !ovf_evt) |=> !ovf_flag_reg)
    else $error("overflow clear write did not clear flag");

  chk_per_clear: assert property (
    (per_clr && !per_evt) |=> !per_flag_reg)
    else $error("periodic clear write did not clear flag");

  chk_rate_reset: assert property (
    $past(rst_i) |-> rate_reg == 2'h3)
    else $error("rate select not slowest after reset");

  chk_por_release: assert property (
    s_por_end |=> s_fresh_count)
    else $error("power-on release did not restart the chain");

  chk_stop_clear: assert property (
    stop_entry |=> !ovf_flag_reg && !per_flag_reg && !ovf_en_reg && !per_en_reg &&
      chain_reg == 17'h00000)
    else $error("stop entry left timer state behind");

  chk_wd_service: assert property (
    (wd_service && !chain_clr) |=> wd_cnt_reg == 3'h0 && chain_reg == $past(chain_reg) + 17'h00001)
    else $error("service disturbed chain or kept divider");

  chk_wd_expiry: assert property (
    wd_expire |=> reset_pin_oe_o && cpu_reset_o && !reset_pin_n_o)
    else $error("watchdog expiry gave no reset");
endmodule : mft_timer

// *** rtl/mft_pkg.sv ***
// Constants, register map and state type of the multi-function timer
package mft_pkg;
  localparam int          ADR_W             = 8;
  localparam int          DAT_W             = 32;
  localparam int          CHAIN_W           = 17;
  // Register indices; the byte address is four times the index
  localparam logic [5:0]  IDX_CTRL_STATUS   = 6'h08;
  localparam logic [5:0]  IDX_COUNT         = 6'h09;
  localparam logic [5:0]  IDX_SYS_CONFIG    = 6'h0a;
  localparam logic [5:0]  IDX_WD_SERVICE    = 6'h0b;
  // timer_control_status fields
  localparam int          BIT_OVF_FLAG      = 7;
  localparam int          BIT_PER_FLAG      = 6;
  localparam int          BIT_OVF_IRQ_EN    = 5;
  localparam int          BIT_PER_IRQ_EN    = 4;
  localparam int          BIT_OVF_CLEAR     = 3;
  localparam int          BIT_PER_CLEAR     = 2;
  localparam int          BIT_RATE_MSB      = 1;
  localparam int          BIT_RATE_LSB      = 0;
  // sys_config fields, then the service register data bit
  localparam int          BIT_WD_ENABLE     = 0;
  localparam int          BIT_REC_LONG      = 1;
  localparam int          BIT_SVC_DATA      = 0;
  // Reset values
  localparam logic [1:0]  RST_RATE          = 2'h3;
  localparam logic        RST_WD_ENABLE     = 1'b1;
  localparam logic        RST_REC_LONG      = 1'b1;
  // Chain layout: prescaler bits 1:0, counter bits 9:2, periodic base tap at bit 13
  localparam int          CNT_LSB           = 2;
  localparam int          CNT_MSB           = 9;
  localparam logic [4:0]  OVF_TAP_MSB       = 5'd9;
  localparam logic [4:0]  PER_TAP_BASE_MSB  = 5'd13;
  // Timing counts, in bus cycles (one clk_i cycle is one bus cycle)
  localparam int          POR_CYCLES        = 4064;
  localparam int          STOP_SHORT_CYCLES = 1024;
  localparam int          STOP_LONG_CYCLES  = 4064;
  localparam int          WD_PULSE_CYCLES   = 16;
  localparam logic [CHAIN_W-1:0] POR_LAST   = CHAIN_W'(POR_CYCLES - 1);
  localparam logic [CHAIN_W-1:0] SHORT_LAST = CHAIN_W'(STOP_SHORT_CYCLES - 1);
  localparam logic [CHAIN_W-1:0] LONG_LAST  = CHAIN_W'(STOP_LONG_CYCLES - 1);
  localparam logic [CHAIN_W-1:0] PULSE_LAST = CHAIN_W'(WD_PULSE_CYCLES - 1);
  localparam logic [2:0]  WD_LAST           = 3'h7;

  typedef enum logic [2:0] {
    MFT_POR,
    MFT_RUN,
    MFT_STOP,
    MFT_RECOVER,
    MFT_WDRST
  } mft_state_e;
endpackage : mft_pkg

// *** rtl/mft_sync.sv ***
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module mft_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : mft_sync

// *** tb/mft_cpu_model.sv ***
// Core-side model: Wishbone classic master and the reset pin pull-up
`timescale 1ns/10ps
module mft_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        pin_oe_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic             pin_n_o
);
  logic ext_low = 1'b0;
  logic hung    = 1'b0;
  // Pin has a pull-up, so it is low while either side pulls it
  assign pin_n_o = !(ext_low || pin_oe_i);
  initial
  begin
    cyc_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
    begin
      n++;
      if (n > 20)
        hung <= 1'b1;
      @(posedge clk_i);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    // Released data must not look like the last value
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
  task automatic service();
    logic [31:0] q;
    xfer(1'b1, 8'h2c, 32'h0, q);
  endtask : service
endmodule : mft_cpu_model

// *** tb/test_multi_function_timer.sv ***
// Self-checking testbench of the multi-function timer
`timescale 1ns/10ps
module test_multi_function_timer;
  import mft_pkg::*;
  localparam logic [7:0] A_CS  = {IDX_CTRL_STATUS, 2'b00};
  localparam logic [7:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [7:0] A_SVC = {IDX_WD_SERVICE, 2'b00};
  localparam logic [7:0] A_CFG = {IDX_SYS_CONFIG, 2'b00};
  localparam int         PER   = 16384;
  localparam int         OVF_PER = 1024;
  localparam int         REC_IRQ = STOP_SHORT_CYCLES + OVF_PER;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        stop_i = 1'b0;
  logic        cyc, we, ack, irq, cpu_rst, oe, pin_o, pin_n;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc_n      = 0;
  int          t0, s, c1;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  mft_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .stop_i(stop_i), .reset_pin_n_i(pin_n), .reset_pin_n_o(pin_o),
    .reset_pin_oe_o(oe), .cpu_reset_o(cpu_rst), .irq_o(irq));
  mft_cpu_model cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .pin_oe_i(oe),
    .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat), .pin_n_o(pin_n));
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge cpu.hung)
  begin
    mismatches++;
    report_and_stop();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cpu.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Polls irq (which 0) or cpu reset (which 1) at each edge, bounded
  task automatic wait_for(input int which, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((which == 0) ? irq : cpu_rst) !== lvl)
    begin
      @(posedge clk_i);
      n++;
      if (n > lim)
      begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_for
  task automatic t_por();
    check(cpu_rst, 1'b1);
    wait_for(1, 1'b0, 5000);
    check((cyc_n - t0 >= POR_CYCLES) && (cyc_n - t0 <= POR_CYCLES + 4), 1'b1);
    rd(A_CNT);
    check(q < 2, 1'b1);
    rd(A_CS);
    check(q, 32'h03);
    rd(8'h3c);
    check(q, 32'h0);
    $display("test por done");
  endtask : t_por
  task automatic t_count();
    wr(A_CNT, 32'hff);
    s = cyc_n;
    rd(A_CNT);
    c1 = q;
    // Equal task lengths, so a start gap of 4k cycles is a count gap of k
    while ((cyc_n - s) % 4 != 0 || cyc_n - s < 200)
      @(posedge clk_i);
    c1 = (c1 + (cyc_n - s) / 4) % 256;
    rd(A_CNT);
    check(q, c1);
    $display("test count done");
  endtask : t_count
  task automatic t_ovf();
    wr(A_CS, 32'h0b);
    repeat (1100) @(posedge clk_i);
    rd(A_CS);
    check(q, 32'h83);
    check(irq, 1'b0);
    wr(A_CS, 32'h23);
    wait_for(0, 1'b1, 4);
    check(irq, 1'b1);
    wr(A_CS, 32'hab);
    rd(A_CS);
    check(q, 32'h23);
    check(irq, 1'b0);
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_ext();
    wr(A_CS, 32'h31);
    cpu.ext_low <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(cpu_rst, 1'b1);
    cpu.ext_low <= 1'b0;
    @(posedge clk_i);
    wait_for(1, 1'b0, 6000);
    rd(A_CS);
    check(q, 32'h03);
    rd(A_CNT);
    check(q < 2, 1'b1);
    $display("test external reset done");
  endtask : t_ext
  task automatic t_per_wd();
    cpu.service();
    wr(A_CS, 32'h1c);
    wait_for(0, 1'b1, PER + 20);
    t0 = cyc_n;
    rd(A_CS);
    check(q[BIT_PER_FLAG], 1'b1);
    wr(A_CS, 32'h14);
    // The interrupt level follows the flag one edge later
    @(posedge clk_i);
    check(irq, 1'b0);
    wr(A_SVC, 32'h1);
    wait_for(0, 1'b1, PER);
    check(cyc_n - t0, PER);
    wait_for(1, 1'b1, 6 * PER + 20);
    check(cyc_n - t0 >= 7 * PER - 3 && cyc_n - t0 <= 7 * PER + 3, 1'b1);
    @(posedge clk_i);
    check({oe, pin_o, pin_n}, 3'b100);
    s = cyc_n;
    wait_for(1, 1'b0, 40);
    check(cyc_n - s >= WD_PULSE_CYCLES - 2 && cyc_n - s <= WD_PULSE_CYCLES + 1, 1'b1);
    rd(A_CS);
    check(q, 32'h03);
    $display("test periodic and watchdog done");
  endtask : t_per_wd
  task automatic t_stop();
    wr(A_CS, 32'h33);
    wait_for(0, 1'b1, 1100);
    stop_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(irq, 1'b0);
    rd(A_CS);
    check(q, 32'h03);
    rd(A_CNT);
    check(q, 32'h0);
    // Short recovery and watchdog off, written while stopped
    wr(A_CFG, 32'h0);
    rd(A_CFG);
    check(q, 32'h0);
    stop_i <= 1'b0;
    s = cyc_n;
    wr(A_CS, 32'h23);
    wait_for(0, 1'b1, REC_IRQ + 20);
    c1 = cyc_n - s;
    check(c1 >= REC_IRQ && c1 <= REC_IRQ + 6, 1'b1);
    $display("test stop done");
  endtask : t_stop
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cyc_n;
    @(posedge clk_i);
    t_por();
    t_count();
    t_ovf();
    t_ext();
    t_per_wd();
    t_stop();
    report_and_stop();
  end
endmodule : test_multi_function_timer
